//--- design/asrw_pkg.sv
// Purpose: shared constants and types of the result word serializer
// Assumes: 100 MHz system clock, 32-bit read-out frame
// Notes:   timing counts derive from these
package asrw_pkg;

    ////////////////////////////////////////
    // clocking
    localparam int unsigned CLOCK_HZ        = 100_000_000;
    localparam int unsigned CLOCK_PERIOD_NS = 10;

    ////////////////////////////////////////
    // frame layout
    localparam int unsigned FRAME_BITS    = 32;
    localparam int unsigned WORD_BITS     = 30;
    localparam int unsigned EOC_POS       = 31;
    localparam int unsigned FILLER_POS    = 30;
    localparam int unsigned SIGN_POS      = 29;
    localparam int unsigned MSB_POS       = 28;
    localparam int unsigned LSB_POS       = 5;
    localparam int unsigned LAST_FALL_IDX = 31;
    localparam logic        FILLER_VALUE  = 1'b0;
    localparam logic        EOC_BUSY      = 1'b1;
    localparam logic        EOC_DONE      = 1'b0;
    localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 32'h8000_0000;

    ////////////////////////////////////////
    // result range and clamp codes
    localparam int                   RAW_MAX   = 268_435_455;
    localparam int                   RAW_MIN   = -268_435_456;
    localparam logic [WORD_BITS-1:0] CLAMP_POS = 30'h3000_0000;
    localparam logic [WORD_BITS-1:0] CLAMP_NEG = 30'h0FFF_FFFF;

    ////////////////////////////////////////
    // conversion clock
    localparam int unsigned NOTCH_DIVIDE    = 2560;
    localparam int unsigned NOTCH_60_HZ     = 60;
    localparam int unsigned NOTCH_50_HZ     = 50;
    localparam int unsigned OSC_DIV_60      = CLOCK_HZ / (NOTCH_60_HZ * NOTCH_DIVIDE);
    localparam int unsigned OSC_DIV_50      = CLOCK_HZ / (NOTCH_50_HZ * NOTCH_DIVIDE);
    localparam int unsigned CONV_TICKS      = 10278;
    localparam int unsigned EXT_MIN_FREQ_HZ = 2560;
    localparam int unsigned EXT_MAX_PERIOD  = CLOCK_HZ / EXT_MIN_FREQ_HZ;
    localparam int unsigned EXT_LOSS_CYCLES = 2 * EXT_MAX_PERIOD;

    ////////////////////////////////////////
    // internally generated serial clock
    localparam int unsigned SCK_HALF_NS     = 26_000;
    localparam int unsigned SCK_HALF_CYCLES = SCK_HALF_NS / CLOCK_PERIOD_NS;

    ////////////////////////////////////////
    // cycle states
    typedef enum logic [2:0] {
        ST_CONVERT = 3'b001,
        ST_SLEEP   = 3'b010,
        ST_OUTPUT  = 3'b100
    } asrw_state_type;

endpackage

//--- design/asrw_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs are slow against the system clock
// Notes:   first stage feeds the second stage only
`timescale 1ns/10ps
module asrw_sync #(
    parameter int unsigned      WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1_q <= RESET_VALUE;
            syncOut  <= RESET_VALUE;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end

endmodule // asrw_sync

//--- design/asrw_buffer.sv
// Purpose: two-entry valid/ready buffer between filter and serializer
// Assumes: single clock
// Notes:   inReady drops when both entries hold words
`timescale 1ns/10ps
module asrw_buffer #(
    parameter int unsigned WIDTH = 30
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);

    logic [WIDTH-1:0] mem_q [2];
    logic             wrPtr_q;
    logic             rdPtr_q;
    logic [1:0]       count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != 2'd2);
    assign outValid = (count_q != 2'd0);
    assign outData  = mem_q[rdPtr_q];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wrPtr_q  <= 1'b0;
        end else if (push) begin
            mem_q[wrPtr_q] <= inData;
            wrPtr_q        <= ~wrPtr_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdPtr_q <= 1'b0;
        end else if (pop) begin
            rdPtr_q <= ~rdPtr_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= 2'd0;
        end else if (push && !pop) begin
            count_q <= count_q + 2'd1;
        end else if (pop && !push) begin
            count_q <= count_q - 2'd1;
        end
    end

endmodule // asrw_buffer

//--- design/adc_result_word_serializer.sv
// Purpose: formats results and shifts them out on a 3-wire link,
//          and times conversions from an internal or external clock
// Assumes: pins are asynchronous; filter results arrive on
//          a valid/ready port as signed raw codes in sub-lsb units
// Notes:   serial clock edges pass the synchroniser, so the external
//          serial clock must be far slower than the system clock
//
// Behaviour
// - frame is 32 bits: three status bits, result, then sub-lsb bits
// - 24-bit result sits in bits 28 to 5, msb first; bits 4-0 sub-lsb
// - bit 31 is active-low done flag: high converting, low when finished
// - with chip select low in convert or sleep, drive done flag in real time
// - bit 30 is always a low filler bit
// - bit 29 is sign: high for zero or positive, low for negative
// - overrange shows bits 29,28 high; underrange shows both low
// - zero, minus one lsb, overrange and underrange give the tabled codes
// - clamp to plus full scale plus one lsb, minus full scale minus one
// - chip select high: data output released, serial clock ignored
// - host samples bit 31 first rise; device shifts next bit each fall
// - bit 0 goes out on the 31st falling serial clock edge
// - 32nd falling edge drives output high as the next done flag
// - internal oscillator: select low gives 60 hz notch, high 50 hz
// - selection changes touch at most the conversion in progress
// - detect toggling select pin as external clock, stop internal oscillator
// - external clock: one conversion spans ticks setting notch at f/2560
// - no external clock: re-enable internal oscillator automatically
// - clock source change spoils at most the running conversion
// - source change during internal serial clock keeps data valid
// - sleep while chip select high; present result at once when low
// - output ends after 32 bits or chip select high, then convert
`timescale 1ns/10ps
module adc_result_word_serializer
    import asrw_pkg::*;
#(
    parameter int unsigned RAW_WIDTH       = 32,
    parameter int unsigned CONV_TICK_COUNT = asrw_pkg::CONV_TICKS,
    parameter int unsigned EXT_LOSS_WINDOW = asrw_pkg::EXT_LOSS_CYCLES
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        chipSelectN,
    input  wire logic                        serialClockIn,
    output logic                             serialClockOut,
    output logic                             serialClockOe,
    output logic                             serialDataOut,
    output logic                             serialDataOe,
    input  wire logic                        rejectionSelectClockPin,
    input  wire logic                        internalSckMode,
    input  wire logic                        filterValid,
    output logic                             filterReady,
    input  wire logic signed [RAW_WIDTH-1:0] filterRaw,
    output logic                             internalOscEnable,
    output logic                             externalClockActive,
    output logic                             rejection50Hz,
    output logic                             conversionBusy
);

    import asrw_pkg::*;

    ////////////////////////////////////////
    // declarations

    localparam logic [2:0] SYNC_RESET = 3'b001;

    logic [2:0]            pinSync;
    logic                  chipSelectSyncN;
    logic                  sclkSync;
    logic                  rejSync;
    logic                  sclkPrev_q;
    logic                  rejPrev_q;
    logic                  extFall;
    logic                  extRise;
    logic                  csLow;

    asrw_state_type        state_q;
    logic [FRAME_BITS-1:0] shift_q;
    logic [4:0]            fallCount_q;
    logic                  sckFall;

    logic [11:0]           sckHalfCount_q;
    logic                  sclkGen_q;
    logic                  sckHalfTick;
    logic                  genFall;
    logic                  genRun;

    logic                  rej50_q;
    logic [9:0]            oscCount_q;
    logic [9:0]            oscLimit;
    logic                  oscTick;
    logic                  extActive_q;
    logic                  seenEdge_q;
    logic [31:0]           gapCount_q;
    logic                  convTick;
    logic [31:0]           convCount_q;
    logic                  timerDone_q;

    logic [WORD_BITS-1:0]  formattedWord;
    logic                  bufValid;
    logic [WORD_BITS-1:0]  bufData;
    logic                  bufPop;

    ////////////////////////////////////////
    // pin synchronisers and edge detection

    asrw_sync #(
        .WIDTH      (3),
        .RESET_VALUE(SYNC_RESET)
    ) u_pin_sync (
        .clock  (clock),
        .rst    (rst),
        .asyncIn({rejectionSelectClockPin, serialClockIn, chipSelectN}),
        .syncOut(pinSync)
    );

    assign chipSelectSyncN = pinSync[0];
    assign sclkSync        = pinSync[1];
    assign rejSync         = pinSync[2];
    assign csLow           = ~chipSelectSyncN;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
            rejPrev_q  <= 1'b0;
        end else begin
            sclkPrev_q <= sclkSync;
            rejPrev_q  <= rejSync;
        end
    end

    // external serial clock only counts while selected
    assign extFall = sclkPrev_q & ~sclkSync & csLow & ~internalSckMode;
    assign extRise = rejSync & ~rejPrev_q;

    ////////////////////////////////////////
    // result formatting and buffer

    // the raw code already carries sign at bit 29 and msb at bit 28
    function automatic logic [WORD_BITS-1:0] format_word(
        input logic signed [RAW_WIDTH-1:0] raw
    );
        if (raw > RAW_MAX) begin
            return CLAMP_POS;
        end else if (raw < RAW_MIN) begin
            return CLAMP_NEG;
        end else begin
            return {~raw[SIGN_POS], raw[MSB_POS:0]};
        end
    endfunction

    assign formattedWord = format_word(filterRaw);

    // a stalled read-out holds the filter off, no word lost
    asrw_buffer #(
        .WIDTH(WORD_BITS)
    ) u_result_buffer (
        .clock   (clock),
        .rst     (rst),
        .inValid (filterValid),
        .inReady (filterReady),
        .inData  (formattedWord),
        .outValid(bufValid),
        .outReady(bufPop),
        .outData (bufData)
    );

    assign bufPop = (state_q == ST_CONVERT) & timerDone_q & bufValid;

    ////////////////////////////////////////
    // external conversion clock detection

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            extActive_q <= 1'b0;
            seenEdge_q  <= 1'b0;
            gapCount_q  <= 32'h0000_0000;
        end else if (extRise) begin
            // one level flip is a selection, two close edges a clock
            if (seenEdge_q && (gapCount_q < EXT_LOSS_WINDOW)) begin
                extActive_q <= 1'b1;
            end
            seenEdge_q <= 1'b1;
            gapCount_q <= 32'h0000_0000;
        end else if (gapCount_q >= EXT_LOSS_WINDOW) begin
            extActive_q <= 1'b0;
            seenEdge_q  <= 1'b0;
        end else begin
            gapCount_q <= gapCount_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////
    // rejection selection and internal oscillator

    // latched outside conversion only, so no result is spoilt
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rej50_q <= 1'b0;
        end else if ((state_q != ST_CONVERT) && !extActive_q) begin
            rej50_q <= rejSync;
        end
    end

    assign oscLimit = rej50_q ? 10'(OSC_DIV_50 - 1) : 10'(OSC_DIV_60 - 1);
    assign oscTick  = ~extActive_q & (oscCount_q == oscLimit);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            oscCount_q <= 10'h000;
        end else if (extActive_q || oscCount_q >= oscLimit) begin
            oscCount_q <= 10'h000;
        end else begin
            oscCount_q <= oscCount_q + 10'h001;
        end
    end

    // a source switch skews only the running conversion
    assign convTick = extActive_q ? extRise : oscTick;

    ////////////////////////////////////////
    // conversion timer

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            convCount_q <= 32'h0000_0000;
            timerDone_q <= 1'b0;
        end else if (state_q != ST_CONVERT) begin
            convCount_q <= 32'h0000_0000;
            timerDone_q <= 1'b0;
        end else if (convTick && !timerDone_q) begin
            if (convCount_q >= CONV_TICK_COUNT - 1) begin
                timerDone_q <= 1'b1;
            end
            convCount_q <= convCount_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////
    // internal serial clock generator

    assign genRun      = internalSckMode & csLow & (state_q == ST_OUTPUT);
    assign sckHalfTick = genRun & (sckHalfCount_q == 12'(SCK_HALF_CYCLES - 1));
    assign genFall     = sckHalfTick & sclkGen_q;

    // runs off the system clock, immune to source switches
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sckHalfCount_q <= 12'h000;
            sclkGen_q      <= 1'b0;
        end else if (!genRun) begin
            sckHalfCount_q <= 12'h000;
            sclkGen_q      <= 1'b0;
        end else if (sckHalfTick) begin
            sckHalfCount_q <= 12'h000;
            sclkGen_q      <= ~sclkGen_q;
        end else begin
            sckHalfCount_q <= sckHalfCount_q + 12'h001;
        end
    end

    assign sckFall = internalSckMode ? genFall : extFall;

    ////////////////////////////////////////
    // cycle state and output shift register

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q     <= ST_CONVERT;
            shift_q     <= SHIFT_RESET;
            fallCount_q <= 5'd0;
        end else begin
            unique case (state_q)
                ST_CONVERT: begin
                    fallCount_q <= 5'd0;
                    if (bufPop) begin
                        // done flag drops the moment the word is in place
                        shift_q <= {EOC_DONE, FILLER_VALUE, bufData};
                        state_q <= ST_SLEEP;
                    end else begin
                        shift_q[EOC_POS] <= EOC_BUSY;
                    end
                end
                ST_SLEEP: begin
                    fallCount_q <= 5'd0;
                    if (csLow) begin
                        state_q <= ST_OUTPUT;
                    end
                end
                ST_OUTPUT: begin
                    if (!csLow) begin
                        shift_q <= SHIFT_RESET;
                        state_q <= ST_CONVERT;
                    end else if (sckFall) begin
                        if (fallCount_q == 5'(LAST_FALL_IDX)) begin
                            shift_q <= SHIFT_RESET;
                            state_q <= ST_CONVERT;
                        end else begin
                            shift_q     <= {shift_q[FRAME_BITS-2:0], 1'b0};
                            fallCount_q <= fallCount_q + 5'd1;
                        end
                    end
                end
                default: begin
                    shift_q <= SHIFT_RESET;
                    state_q <= ST_CONVERT;
                end
            endcase
        end
    end

    ////////////////////////////////////////
    // pin drivers and status

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serialDataOe <= 1'b0;
        end else begin
            serialDataOe <= csLow;
        end
    end

    assign serialDataOut       = shift_q[EOC_POS];
    assign serialClockOut      = sclkGen_q;
    assign serialClockOe       = internalSckMode;
    assign internalOscEnable   = ~extActive_q;
    assign externalClockActive = extActive_q;
    assign rejection50Hz       = rej50_q;
    assign conversionBusy      = (state_q == ST_CONVERT);

endmodule // adc_result_word_serializer

//--- dv/asrw_host_model.sv
// Purpose: host side of the read-out link, external serial clock
// Assumes: pins change on the falling system clock edge
// Notes:   a released data line toggles, never stale
`timescale 1ns/10ps
module asrw_host_model #(
    parameter int unsigned HALF = 8
) (
    input  wire logic clock,
    input  wire logic serialDataOut,
    input  wire logic serialDataOe,
    output logic      chipSelectN,
    output logic      serialClockIn
);
    logic lastSdo;
    logic sdoWire;
    logic [31:0] bits;
    assign sdoWire = serialDataOe ? serialDataOut : ~lastSdo;
    initial begin
        chipSelectN   = 1'b1;
        serialClockIn = 1'b0;
        lastSdo       = 1'b0;
    end
    always @(posedge clock) lastSdo <= sdoWire;
    ////////////////////////////////////////
    // deselected pulses must leave the frame intact sample on rises
    task pulse(input int n);
        repeat (n) begin
            repeat (HALF) @(negedge clock);
            serialClockIn = 1'b1;
            bits = {bits[30:0], sdoWire};
            repeat (HALF) @(negedge clock);
            serialClockIn = 1'b0;
        end
    endtask
    // select, wait for the done flag, clock n bits msb first
    task readFrame(input int n, output logic [31:0] w, output logic endLvl);
        int k;
        k = 0;
        bits = '0;
        @(negedge clock);
        chipSelectN = 1'b0;
        repeat (6) @(negedge clock);
        while (sdoWire !== 1'b0 && k < 20000) begin
            @(negedge clock);
            k++;
        end
        pulse(n);
        w = bits;
        repeat (HALF) @(negedge clock);
        endLvl      = sdoWire;
        chipSelectN = 1'b1;
    endtask
endmodule // asrw_host_model

//--- dv/asrw_checker.sv
// Purpose: port level checks of the serializer
// Assumes: external serial clock, one clock domain
// Notes:   bounds allow for the pin synchroniser
`timescale 1ns/10ps
module asrw_checker #(
    parameter int unsigned EXT_LOSS_WINDOW = 200
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic chipSelectN,
    input wire logic serialClockIn,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    input wire logic rejectionSelectClockPin,
    input wire logic internalOscEnable,
    input wire logic externalClockActive,
    input wire logic rejection50Hz,
    input wire logic conversionBusy
);
    int unsigned idleCnt;
    int unsigned fallCnt;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // saturates, never wraps
    always_ff @(posedge clock or posedge rst) begin
        if (rst) idleCnt <= 0;
        else if ($changed(rejectionSelectClockPin)) idleCnt <= 0;
        else if (idleCnt < EXT_LOSS_WINDOW + 100) idleCnt <= idleCnt + 1;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) fallCnt <= 0;
        else if (chipSelectN) fallCnt <= 0;
        else if ($fell(serialClockIn)) fallCnt <= fallCnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence sckHeld;
        serialClockIn[*6];
    endsequence
    sequence frameDone;
        fallCnt == 32;
    endsequence
    chk_oe_tracks_cs:
    assert property ($stable(chipSelectN)[*4] |-> serialDataOe == !chipSelectN)
        else $error("oe not tracking cs");
    chk_busy_flag_high:
    assert property (conversionBusy |-> serialDataOut) else $error("flag low in convert");
    chk_done_flag_low:
    assert property ($fell(conversionBusy) |-> !serialDataOut) else $error("done flag not low");
    chk_sleep_holds:
    assert property ((!conversionBusy && chipSelectN)[*8] |=> !conversionBusy)
        else $error("left sleep");
    chk_data_hold:
    assert property (sckHeld |-> $stable(serialDataOut)) else $error("data moved");
    chk_frame_end:
    assert property (frameDone |-> ##[0:8] (conversionBusy && serialDataOut))
        else $error("no restart after frame");
    chk_abort_restart:
    assert property ($rose(chipSelectN) && !conversionBusy && !$past(chipSelectN, 6)
        |-> ##[1:6] conversionBusy) else $error("abort did not restart");
    chk_sel_frozen:
    assert property (conversionBusy && $past(conversionBusy) |-> $stable(rejection50Hz))
        else $error("selection moved");
    chk_sel_latch:
    assert property ((!conversionBusy && !externalClockActive
        && $stable(rejectionSelectClockPin))[*8] |-> rejection50Hz == rejectionSelectClockPin)
        else $error("selection not taken");
    chk_ext_loss:
    assert property (idleCnt > EXT_LOSS_WINDOW + 8 |-> !externalClockActive)
        else $error("ext clock kept");
    chk_osc_exclusive:
    assert property (internalOscEnable != externalClockActive) else $error("oscillator clash");
endmodule // asrw_checker

bind adc_result_word_serializer asrw_checker #(.EXT_LOSS_WINDOW(EXT_LOSS_WINDOW)) asrw_checker_i (
    .clock(clock), .rst(rst), .chipSelectN(chipSelectN), .serialClockIn(serialClockIn),
    .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
    .rejectionSelectClockPin(rejectionSelectClockPin), .internalOscEnable(internalOscEnable),
    .externalClockActive(externalClockActive), .rejection50Hz(rejection50Hz),
    .conversionBusy(conversionBusy)
);

//--- dv/tb.sv
// Purpose: self-checking bench of the result word serializer
// Assumes: external serial clock only; conversion count cut to 10 ticks
// Notes:   internal serial clock frames are too long for this run
`timescale 1ns/10ps
module tb;
    import asrw_pkg::*;
    localparam int unsigned TICKS = 10;
    localparam int unsigned LOSS  = 200;
    localparam int unsigned EXT_P = 40;
    logic               clock, rst, rejectionSelectClockPin, filterValid, extRun, endLvl;
    logic               chipSelectN, serialClockIn, serialDataOut, serialDataOe, filterReady;
    logic               internalOscEnable, externalClockActive, rejection50Hz, conversionBusy;
    logic signed [31:0] filterRaw;
    logic        [31:0] w;
    int                 error_cnt, total_checks, busyCnt, lastConv;
    logic signed [31:0] vals [6] = '{'0, -32, RAW_MAX, RAW_MAX + 1, RAW_MIN, RAW_MIN - 1};

    adc_result_word_serializer #(.CONV_TICK_COUNT(TICKS),
        .EXT_LOSS_WINDOW(LOSS)) adc_result_word_serializer_i (
        .clock(clock), .rst(rst), .chipSelectN(chipSelectN), .serialClockIn(serialClockIn),
        .serialClockOut(), .serialClockOe(), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .rejectionSelectClockPin(rejectionSelectClockPin),
        .internalSckMode(1'b0), .filterValid(filterValid), .filterReady(filterReady),
        .filterRaw(filterRaw), .internalOscEnable(internalOscEnable),
        .externalClockActive(externalClockActive), .rejection50Hz(rejection50Hz),
        .conversionBusy(conversionBusy));
    asrw_host_model asrw_host_model_i (.clock(clock), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .chipSelectN(chipSelectN), .serialClockIn(serialClockIn));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (conversionBusy === 1'b1) busyCnt <= busyCnt + 1;
        else if (busyCnt != 0) begin
            lastConv <= busyCnt;
            busyCnt  <= 0;
        end
    end
    initial forever begin
        repeat (EXT_P / 2) @(negedge clock);
        if (extRun) rejectionSelectClockPin <= ~rejectionSelectClockPin;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitFor(ref logic s, input logic v, input int lim);
        int k = 0;
        while (s !== v && k < lim) begin
            @(negedge clock);
            k++;
        end
        check(s, v);
    endtask
    task push(input logic signed [31:0] raw);
        int k;
        k = 0;
        @(negedge clock);
        filterValid = 1'b1;
        filterRaw   = raw;
        while (filterReady !== 1'b1 && k < 20000) begin
            @(negedge clock);
            k++;
        end
        @(negedge clock);
        filterValid = 1'b0;
    endtask
    // first tick may lag the start by one divider period
    task convLen(input int div);
        check(lastConv >= (TICKS - 1) * div && lastConv <= (TICKS + 1) * div + 20, 1'b1);
    endtask
    function automatic logic [31:0] frameOf(input logic signed [31:0] raw);
        if (raw > RAW_MAX) return 32'h3000_0000;
        if (raw < RAW_MIN) return 32'h0FFF_FFFF;
        return {2'b00, ~raw[29], raw[28:0]};
    endfunction
    task readCheck(input logic signed [31:0] raw);
        asrw_host_model_i.readFrame(32, w, endLvl);
        check(w, frameOf(raw));
        check({endLvl, conversionBusy}, 2'b11);
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        {rst, filterValid, filterRaw, rejectionSelectClockPin, extRun} = {1'b1, 35'h0_0000_0000};
        {error_cnt, total_checks, busyCnt, lastConv} = '0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        check({filterReady, internalOscEnable, rejection50Hz, serialDataOe}, 4'b1100);
        push(vals[0]);
        push(vals[1]);
        repeat (2) @(negedge clock);
        check(filterReady, 1'b0);
        for (int i = 0; i < 6; i++) begin
            if (i > 1) push(vals[i]);
            if (i > 0) waitFor(conversionBusy, 1'b0, 20000);
            if (i == 1) asrw_host_model_i.pulse(5);
            if (i == 2) begin
                rejectionSelectClockPin = 1'b1;
                repeat (6) @(negedge clock);
                check(rejection50Hz, 1'b1);
            end
            readCheck(vals[i]);
            convLen((i > 2) ? OSC_DIV_50 : OSC_DIV_60);
        end
        push(32'sh0000_1234);
        extRun = 1'b1;
        waitFor(externalClockActive, 1'b1, 2000);
        check(internalOscEnable, 1'b0);
        readCheck(32'sh0000_1234);
        push(-64);
        readCheck(-64);
        convLen(EXT_P);
        extRun = 1'b0;
        waitFor(externalClockActive, 1'b0, LOSS + 100);
        check(internalOscEnable, 1'b1);
        push(vals[0]);
        asrw_host_model_i.readFrame(8, w, endLvl);
        check(w, 32'h0000_0020);
        repeat (6) @(negedge clock);
        check(conversionBusy, 1'b1);
        check(filterReady, 1'b1);
        summarize();
    end
endmodule // tb
